// File: tcw_timer_ctrl.sv
// Purpose: Timer/counter control: width, waveform operation, delayed enable
// Assumes: Single clock, strobes from same-domain logic, one-cycle read latency
// Notes:   Enable takes effect after SYNC_CYCLES clocks, tracked by sync busy
//
// Contract
// - A two-bit selector picks frequency (0x0, 0x1) or pulse-width (0x2, 0x3) generation.
// - Frequency operations toggle the output on match and leave it alone on wraparound.
// - Match-frequency and match-PWM use channel 0 compare as top, the others the normal top.
// - Normal operations in 8-bit width use the period value as top.
// - Normal operations in 16- or 32-bit width use the maximum count as top.
// - PWM clears on match and sets on wrap counting up, and the opposite counting down.
// - Waveform selector writes apply directly and only while the timer is disabled.
// - Width field decodes 0x0 as 16-bit, 0x1 as 8-bit, 0x2 as 32-bit; 0x3 is reserved.
// - Width field writes apply directly and only while the timer is disabled.
// - The timer follows a written enable bit only after a synchronisation delay.
// - A read returns the newly written enable bit at once.
// - Writing the enable bit sets the enable sync busy flag.
// - The enable sync busy flag clears when the enable or disable has finished.
// - Enable bit writes are taken whether the timer is on or off.
// - Enable-protected fields ignore writes while the timer is enabled.
// - Direction bit 0 means counting up and 1 counting down for PWM decisions.

`timescale 1ns/1ps

module tcw_timer_ctrl (
  input  wire logic        sys_clk_in,
  input  wire logic        arst_n_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [31:0] rdata_out,
  output logic             wave_out,
  output logic             active_out
);

  typedef struct packed {
    tcw_pkg::tcw_wave_type  wave;
    tcw_pkg::tcw_width_type width;
    logic                   en_bit;
    logic                   active;
    logic                   busy;
    logic [1:0]             sync_cnt;
    logic                   dir;
    logic [7:0]             period;
    logic [31:0]            cmp0;
    logic [31:0]            cmp1;
    logic [31:0]            count;
    logic                   wave_lvl;
    logic [31:0]            rdata;
  } tcw_state_type;

  tcw_state_type state_ff;
  tcw_state_type nxt_state;
  logic          rst_meta_ff;
  logic          rst_sync_n_ff;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rst_meta_ff   <= 1'b0;
      rst_sync_n_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff   <= 1'b1;
      rst_sync_n_ff <= rst_meta_ff;
    end
  end

  // Helper values derived from current state
  logic [31:0] width_mask;
  logic [31:0] top_val;
  logic [31:0] match_val;
  logic        is_pwm;
  logic        is_match_top;
  logic        hit_match;
  logic        hit_wrap;
  logic        protected_ok;

  always_comb
  begin
    // Reserved width falls back to 16-bit; never programmed by software
    // width decode
    unique case (state_ff.width)
      tcw_pkg::WIDTH8_COUNTING:  width_mask = tcw_pkg::MAX8;
      tcw_pkg::WIDTH32_COUNTING: width_mask = tcw_pkg::MAX32;
      default:                   width_mask = tcw_pkg::MAX16;
    endcase

    is_pwm       = state_ff.wave[1];
    is_match_top = state_ff.wave[0];

    if (is_match_top)
    begin
      top_val = state_ff.cmp0 & width_mask;
    end
    else if (state_ff.width == tcw_pkg::WIDTH8_COUNTING)
    begin
      top_val = {24'h00_0000, state_ff.period};
    end
    else
    begin
      top_val = width_mask;
    end

    // Match-PWM uses channel 0 as period, so the duty compare is channel 1
    if (state_ff.wave == tcw_pkg::MATCH_PULSE_WIDTH_WAVE)
    begin
      match_val = state_ff.cmp1 & width_mask;
    end
    else
    begin
      match_val = state_ff.cmp0 & width_mask;
    end

    hit_match = state_ff.active && (state_ff.count == match_val);
    hit_wrap  = state_ff.active &&
                (state_ff.dir ? (state_ff.count == tcw_pkg::ZERO32) : (state_ff.count == top_val));

    protected_ok = !state_ff.en_bit && !state_ff.active;
  end

  // Next-state logic for registers, sync tracking, counter and output
  always_comb
  begin
    nxt_state       = state_ff;
    nxt_state.rdata = tcw_pkg::ZERO32;

    // Sync countdown; the timer state follows once it expires
    // delayed enable
    if (state_ff.busy)
    begin
      if (state_ff.sync_cnt == 2'h1)
      begin
        nxt_state.active = state_ff.en_bit;
        nxt_state.busy   = 1'b0;
      end
      nxt_state.sync_cnt = state_ff.sync_cnt - 2'h1;
    end

    // Counter: wrap to the other end, else step by direction
    if (state_ff.active)
    begin
      if (hit_wrap)
      begin
        nxt_state.count = state_ff.dir ? top_val : tcw_pkg::ZERO32;
      end
      else if (state_ff.dir)
      begin
        nxt_state.count = (state_ff.count - 32'h0000_0001) & width_mask;
      end
      else
      begin
        nxt_state.count = (state_ff.count + 32'h0000_0001) & width_mask;
      end
    end

    // Output actions; wrap wins when both land on one clock
    if (is_pwm)
    begin
      if (hit_wrap)
      begin
        nxt_state.wave_lvl = !state_ff.dir;
      end
      else if (hit_match)
      begin
        nxt_state.wave_lvl = state_ff.dir;
      end
    end
    else
    begin
      if (hit_match)
      begin
        nxt_state.wave_lvl = !state_ff.wave_lvl;
      end
    end

    // Register writes
    if (wr_in)
    begin
      unique case (addr_in)
        tcw_pkg::OFS_CONTROL_A:
        begin
          nxt_state.en_bit   = wdata_in[tcw_pkg::CA_ENABLE_BIT];
          nxt_state.busy     = 1'b1;
          nxt_state.sync_cnt = tcw_pkg::SYNC_CYCLES;
          if (protected_ok)
          begin
            nxt_state.wave  = tcw_pkg::tcw_wave_type'(wdata_in[tcw_pkg::CA_WAVE_LSB +: 2]);
            nxt_state.width = tcw_pkg::tcw_width_type'(wdata_in[tcw_pkg::CA_WIDTH_LSB +: 2]);
          end
        end
        tcw_pkg::OFS_DIRECTION:
        begin
          nxt_state.dir = wdata_in[tcw_pkg::DIR_BIT];
        end
        tcw_pkg::OFS_PERIOD:
        begin
          nxt_state.period = wdata_in[7:0];
        end
        tcw_pkg::OFS_CH0_CMP:
        begin
          nxt_state.cmp0 = wdata_in;
        end
        tcw_pkg::OFS_CH1_CMP:
        begin
          nxt_state.cmp1 = wdata_in;
        end
        tcw_pkg::OFS_COUNT:
        begin
          // Software load goes straight to the counter
          nxt_state.count = wdata_in & width_mask;
        end
        default:
        begin
          // Unmapped or read-only: write dropped
        end
      endcase
    end

    // Register reads, answered on the next clock
    if (rd_in)
    begin
      unique case (addr_in)
        tcw_pkg::OFS_CONTROL_A:
        begin
          nxt_state.rdata[tcw_pkg::CA_WAVE_LSB +: 2]  = state_ff.wave;
          nxt_state.rdata[tcw_pkg::CA_WIDTH_LSB +: 2] = state_ff.width;
          nxt_state.rdata[tcw_pkg::CA_ENABLE_BIT]     = state_ff.en_bit;
        end
        tcw_pkg::OFS_DIRECTION:
        begin
          nxt_state.rdata[tcw_pkg::DIR_BIT] = state_ff.dir;
        end
        tcw_pkg::OFS_PERIOD:
        begin
          nxt_state.rdata[7:0] = state_ff.period;
        end
        tcw_pkg::OFS_CH0_CMP:
        begin
          nxt_state.rdata = state_ff.cmp0;
        end
        tcw_pkg::OFS_CH1_CMP:
        begin
          nxt_state.rdata = state_ff.cmp1;
        end
        tcw_pkg::OFS_COUNT:
        begin
          nxt_state.rdata = state_ff.count;
        end
        tcw_pkg::OFS_SYNC_BUSY:
        begin
          nxt_state.rdata[tcw_pkg::SB_ENABLE_BIT] = state_ff.busy;
        end
        default:
        begin
          nxt_state.rdata = tcw_pkg::ZERO32;
        end
      endcase
    end
  end

  // Whole state registered on one edge
  always_ff @(posedge sys_clk_in or negedge rst_sync_n_ff)
  begin
    if (!rst_sync_n_ff)
    begin
      state_ff.wave     <= tcw_pkg::NORMAL_FREQ_WAVE;
      state_ff.width    <= tcw_pkg::WIDTH16_COUNTING;
      state_ff.en_bit   <= 1'b0;
      state_ff.active   <= 1'b0;
      state_ff.busy     <= 1'b0;
      state_ff.sync_cnt <= 2'h0;
      state_ff.dir      <= 1'b0;
      state_ff.period   <= tcw_pkg::PERIOD_RST;
      state_ff.cmp0     <= tcw_pkg::ZERO32;
      state_ff.cmp1     <= tcw_pkg::ZERO32;
      state_ff.count    <= tcw_pkg::ZERO32;
      state_ff.wave_lvl <= 1'b0;
      state_ff.rdata    <= tcw_pkg::ZERO32;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // Outputs straight from flops
  assign rdata_out  = state_ff.rdata;
  assign wave_out   = state_ff.wave_lvl;
  assign active_out = state_ff.active;

endmodule : tcw_timer_ctrl

// File: tcw_pkg.sv
// Purpose: Shared constants and types for the timer waveform/enable control block
// Assumes: 32-bit register port, word addresses are byte offsets on 4-byte steps
// Notes:   Bit positions of control_a follow the documented layout

package tcw_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CONTROL_A  = 8'h00;
  localparam logic [7:0] OFS_DIRECTION  = 8'h04;
  localparam logic [7:0] OFS_PERIOD     = 8'h08;
  localparam logic [7:0] OFS_CH0_CMP    = 8'h0C;
  localparam logic [7:0] OFS_CH1_CMP    = 8'h10;
  localparam logic [7:0] OFS_COUNT      = 8'h14;
  localparam logic [7:0] OFS_SYNC_BUSY  = 8'h18;

  // control_a, sync busy and direction field positions
  localparam int CA_ENABLE_BIT   = 1;
  localparam int CA_WIDTH_LSB    = 2;
  localparam int CA_WAVE_LSB     = 5;
  localparam int SB_ENABLE_BIT   = 1;
  localparam int DIR_BIT         = 0;

  // Reset values
  localparam logic [1:0]  WAVE_RST   = 2'h0;
  localparam logic [1:0]  WIDTH_RST  = 2'h0;
  localparam logic [7:0]  PERIOD_RST = 8'hFF;
  localparam logic [31:0] ZERO32     = 32'h0000_0000;

  // Counter maxima
  localparam logic [31:0] MAX8  = 32'h0000_00FF;
  localparam logic [31:0] MAX16 = 32'h0000_FFFF;
  localparam logic [31:0] MAX32 = 32'hFFFF_FFFF;

  // Clocks from enable write until the timer state follows it
  localparam logic [1:0] SYNC_CYCLES = 2'h3;

  // Waveform operations
  typedef enum logic [1:0] {
    NORMAL_FREQ_WAVE        = 2'h0,
    MATCH_FREQ_WAVE         = 2'h1,
    NORMAL_PULSE_WIDTH_WAVE = 2'h2,
    MATCH_PULSE_WIDTH_WAVE  = 2'h3
  } tcw_wave_type;

  // Counter widths
  typedef enum logic [1:0] {
    WIDTH16_COUNTING = 2'h0,
    WIDTH8_COUNTING  = 2'h1,
    WIDTH32_COUNTING = 2'h2,
    WIDTH_RESERVED   = 2'h3
  } tcw_width_type;

endpackage : tcw_pkg

// File: tcw_assertions.sv
// Purpose: Port-level checks for the timer control block
// Assumes: One clock, register strobes one cycle long
// Notes:   Shadows track what control_a reads must show
`timescale 1ns/1ps
module tcw_assertions (
  input  wire logic        sys_clk_in,
  input  wire logic        arst_n_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  input  wire logic [31:0] rdata_out,
  input  wire logic        wave_out,
  input  wire logic        active_out
);
  logic       en_ff;
  logic [4:0] fld_ff;
  logic [2:0] quiet_ff;
  logic       ca_wr;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);
  // Write to control_a
  assign ca_wr = wr_in && (addr_in == 8'h00);
  // Shadows; fields move only while fully disabled
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      en_ff    <= 1'b0;
      fld_ff   <= 5'h00;
      quiet_ff <= 3'h7;
    end
    else
    begin
      if (ca_wr)
        en_ff <= wdata_in[1];
      if (ca_wr && !en_ff && !active_out)
        fld_ff <= {wdata_in[6:5], 1'b0, wdata_in[3:2]};
      if (ca_wr)
        quiet_ff <= 3'h0;
      else if (quiet_ff != 3'h7)
        quiet_ff <= quiet_ff + 3'h1;
    end
  end
  // Enable write then three quiet cycles
  sequence s_en_wr(b);
    ca_wr && (wdata_in[1] == b) ##1 !wr_in [*3];
  endsequence
  sequence s_busy_rd;
    ca_wr ##2 (rd_in && (addr_in == 8'h18));
  endsequence
  property p_en_on;    s_en_wr(1'b1) |=> active_out; endproperty
  property p_dis;      s_en_wr(1'b0) |=> !active_out; endproperty
  property p_en_late;  ca_wr && wdata_in[1] && !en_ff && !active_out |=> !active_out [*2]; endproperty
  property p_ctrl_en;  rd_in && (addr_in == 8'h00) |=> rdata_out[1] == $past(en_ff); endproperty
  property p_ctrl_prot;
    rd_in && (addr_in == 8'h00) |=> rdata_out[6:2] == $past(fld_ff);
  endproperty
  property p_busy_set; s_busy_rd |=> rdata_out[1]; endproperty
  property p_busy_clr; rd_in && (addr_in == 8'h18) && (quiet_ff >= 3'h4) |=> !rdata_out[1]; endproperty
  property p_hold;     !active_out [*3] |-> $stable(wave_out); endproperty
  a_en_on:     assert property (p_en_on) else $error("timer not on after enable");
  a_dis:       assert property (p_dis) else $error("timer not off after disable");
  a_en_late:   assert property (p_en_late) else $error("timer on too early");
  a_ctrl_en:   assert property (p_ctrl_en) else $error("enable readback wrong");
  a_ctrl_prot: assert property (p_ctrl_prot) else $error("protected fields wrong");
  a_busy_set:  assert property (p_busy_set) else $error("busy flag not set");
  a_busy_clr:  assert property (p_busy_clr) else $error("busy flag stuck");
  a_hold:      assert property (p_hold) else $error("output moved while off");
endmodule : tcw_assertions

// File: tb.sv
// Purpose: Self-checking bench for the timer control block
// Assumes: Strobes driven at rising edges, one-cycle read latency
// Notes:   Waveform timing measured in 8-bit width to keep runs short
`timescale 1ns/1ps
module tb;
  logic        sys_clk_in = 1'b0;
  logic        arst_n_in  = 1'b0;
  logic [7:0]  addr_in    = 8'h00;
  logic [31:0] wdata_in   = 32'h0000_0000;
  logic        wr_in      = 1'b0;
  logic        rd_in      = 1'b0;
  logic [31:0] rdata_out;
  logic        wave_out;
  logic        active_out;
  logic        act_seen;
  int          n_fail          = 0;
  int          samples_checked = 0;
  // Free-running 20 MHz clock
  always #25 sys_clk_in = ~sys_clk_in;
  tcw_timer_ctrl i_dut (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .wave_out(wave_out), .active_out(active_out));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // Gap cycle after each strobe avoids double drives
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
    @(posedge sys_clk_in);
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    @(negedge sys_clk_in);
    act_seen = active_out;
    chk("register read", exp, rdata_out);
    @(posedge sys_clk_in);
  endtask : rdchk
  // Reset values, unmapped address reads zero
  task automatic t_reset();
    logic [7:0]  ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C};
    logic [31:0] rv [8] = '{32'h0, 32'h0, 32'hFF, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    foreach (ra[i])
      rdchk(ra[i], rv[i]);
  endtask : t_reset
  task automatic t_enable();
    wr(8'h00, 32'h2);
    rdchk(8'h00, 32'h2);
    chk("active early", 32'h0, {31'h0, act_seen});
    wr(8'h00, 32'h2);
    rdchk(8'h18, 32'h2);
    chk("active late", 32'h1, {31'h0, act_seen});
    repeat (2) @(posedge sys_clk_in);
    rdchk(8'h18, 32'h0);
  endtask : t_enable
  task automatic t_prot();
    wr(8'h00, 32'h66);
    rdchk(8'h00, 32'h2);
    wr(8'h00, 32'h0);
    repeat (4) @(posedge sys_clk_in);
    rdchk(8'h00, 32'h0);
    chk("active off", 32'h0, {31'h0, act_seen});
    // Every selector code, widths cycled alongside
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h00, (i << 5) | ((i % 3) << 2));
      rdchk(8'h00, (i << 5) | ((i % 3) << 2));
    end
  endtask : t_prot
  // Disable first so protected fields accept the setup
  task automatic cfg(input logic [1:0] wv, input logic [1:0] wd, input logic dr,
                     input logic [31:0] period_value, input logic [31:0] c0, input logic [31:0] c1);
    wr(8'h00, 32'h0);
    repeat (4) @(posedge sys_clk_in);
    wr(8'h04, {31'h0, dr});
    wr(8'h08, period_value);
    wr(8'h0C, c0);
    wr(8'h10, c1);
    wr(8'h14, 32'h0);
    wr(8'h00, {25'h0, wv, 1'b0, wd, 2'b10});
  endtask : cfg
  // Bounded measure of one high and one low phase
  task automatic pw(input int hi, input int lo);
    int k = 0;
    int h = 0;
    int l = 0;
    while (wave_out !== 1'b0 && k < 900) begin @(negedge sys_clk_in); k++; end
    while (wave_out !== 1'b1 && k < 900) begin @(negedge sys_clk_in); k++; end
    while (wave_out === 1'b1 && k < 900) begin @(negedge sys_clk_in); k++; h++; end
    while (wave_out === 1'b0 && k < 900) begin @(negedge sys_clk_in); k++; l++; end
    // Timeout goes straight to the verdict; nothing runs after it
    if (k >= 900)
    begin
      chk("wave timeout", 32'h0, 32'h1);
      end_of_test();
    end
    else
    begin
      chk("high cycles", hi, h);
      chk("low cycles", lo, l);
      @(posedge sys_clk_in);
    end
  endtask : pw
  task automatic t_wave();
    logic w;
    cfg(2'h1, 2'h1, 1'b0, 32'hFF, 32'h3, 32'h0);
    pw(4, 4);
    cfg(2'h0, 2'h1, 1'b0, 32'h5, 32'h2, 32'h0);
    pw(6, 6);
    // Sampled off the edge; one early toggle, then none while climbing to the wide top
    cfg(2'h0, 2'h0, 1'b0, 32'h5, 32'h2, 32'h0);
    repeat (30) @(negedge sys_clk_in);
    w = wave_out;
    repeat (30) @(negedge sys_clk_in);
    chk("wide top", {31'h0, w}, {31'h0, wave_out});
    @(posedge sys_clk_in);
    // Active three clocks after the enable edge, then one step a clock; period top would wrap to 0 after 5
    rdchk(8'h14, 32'h0000_003A);
    cfg(2'h3, 2'h1, 1'b0, 32'hFF, 32'h7, 32'h2);
    pw(3, 5);
    cfg(2'h3, 2'h1, 1'b1, 32'hFF, 32'h7, 32'h2);
    pw(2, 6);
    cfg(2'h2, 2'h1, 1'b0, 32'h9, 32'h3, 32'h0);
    pw(4, 6);
  endtask : t_wave
  initial
  begin
    repeat (10) @(posedge sys_clk_in);
    arst_n_in <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    t_reset();
    t_enable();
    t_prot();
    t_wave();
    end_of_test();
  end
endmodule : tb
bind tcw_timer_ctrl tcw_assertions i_chk (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .wave_out(wave_out), .active_out(active_out));
